// *** rtl/mbeq_defines.vh ***
`ifndef MBEQ_DEFINES_VH
`define MBEQ_DEFINES_VH
// ======================================
// register byte addresses
`define MBEQ_A_CTRL      8'h00
`define MBEQ_A_STAT      8'h04
`define MBEQ_A_OUT0      8'h10
`define MBEQ_A_OUT1      8'h14
// band words: 8'h40 + set*8'h20 + band*4, bands 0..5
`define MBEQ_A_BANDPAGE  2'h1
`define MBEQ_NBAND_MAX   3'h6
// ======================================
// band word fields
`define MBEQ_GAIN_MSB    10
`define MBEQ_GAIN_LSB    0
`define MBEQ_FREQ_MSB    18
`define MBEQ_FREQ_LSB    11
`define MBEQ_WID_MSB     31
`define MBEQ_WID_LSB     19
// output word fields
`define MBEQ_OUT_MUTE    11
`define MBEQ_OUT_BYP     12
// ======================================
// ranges, gain in 0.1 dB, width in 0.001 oct
`define MBEQ_GAIN_MIN    11'h4EA
`define MBEQ_GAIN_MAX    11'h0F0
`define MBEQ_FREQ_MAX    8'h8B
`define MBEQ_WID_MIN     13'h000A
`define MBEQ_WID_MAX     13'h1388
// ======================================
// reset values
`define MBEQ_RST_BAND    32'h1F41E000
`define MBEQ_RST_OUT     13'h0000
`define MBEQ_RST_VAR     2'h1
// ======================================
// variants
`define MBEQ_V_3BAND     2'h0
`define MBEQ_V_5BAND     2'h1
`define MBEQ_V_DUAL      2'h2
`define MBEQ_V_MONO      2'h3
// ======================================
// arithmetic constants
`define MBEQ_UNITY12     32'h00001000
`define MBEQ_ONE16       32'h00010000
`define MBEQ_Q_FIXED     32'h0000B505
`define MBEQ_Q_MAX       32'h0001FFFF
`define MBEQ_DB_TO_OCT   32'h00000044
`define MBEQ_SEMI_TO_OCT 32'h00000155
`define MBEQ_WID_TO_Q    32'h0000002E
`endif

// *** rtl/mbeq_top.v ***
// Summary of operation
// - low and high shelves plus one to four peaking bands per variant.
// - the three-band variant has a fixed bandwidth on its one peak.
// - stereo three- and five-band variants share one set for both sides.
// - the dual variant has separate sets, bypass and level per side.
// - the mono variant runs one channel with shelves and four peaks.
// - bypass skips the tone filters of that channel.
// - output level is mute or -79.0 to 24.0 dB at the effect output in all but the three-band variant.
// - low shelf level -79.0 to 24.0 dB acts below its corner.
// - high shelf level -79.0 to 24.0 dB acts above its corner.
// - low shelf corner is 8 to 25088 Hz in semitone steps.
// - high shelf corner is 8 to 25088 Hz in semitone steps.
// - each peak boosts or cuts most at its centre, -79.0 to 24.0 dB.
// - each peak centre is 8 to 25088 Hz in semitone steps.
// - peak width is 0.010 to 5.000 octaves, small is narrow.
// - levels are in dB, 6 dB about doubling amplitude.
`include "mbeq_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module mbeq_top #(
	parameter SAMPLE_RATE = 48000,
	parameter DW          = 16
) (
	input  wire          clk_sys,
	input  wire          rstn,
	input  wire          psel,
	input  wire          penable,
	input  wire          pwrite,
	input  wire [7:0]    paddr,
	input  wire [31:0]   pwdata,
	output wire          pready,
	output reg  [31:0]   prdata,
	output reg           pslverr,
	input  wire          inValid,
	output wire          inReady,
	input  wire [DW-1:0] inLeft,
	input  wire [DW-1:0] inRight,
	output wire          outValid,
	input  wire          outReady,
	output wire [DW-1:0] outLeft,
	output wire [DW-1:0] outRight
);
	localparam [31:0] FBASE = ((6283 * 65536 / SAMPLE_RATE) * 8) / 1000;
	localparam signed [31:0] SMAX = (32'sd1 <<< (DW - 1)) - 32'sd1;
	localparam signed [31:0] SMIN = -(32'sd1 <<< (DW - 1));
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_BAND = 2'h1;
	localparam [1:0] S_OUTG = 2'h2;
	localparam [1:0] S_PUSH = 2'h3;

	// ======================================
	// decode and arithmetic helpers
	function bandHit;
		input [7:0] a;
		bandHit = (a[7:6] == `MBEQ_A_BANDPAGE) && (a[1:0] == 2'h0)
			&& (a[4:2] < `MBEQ_NBAND_MAX);
	endfunction

	function [3:0] bandIndex;
		input [7:0] a;
		bandIndex = (a[5] ? 4'h6 : 4'h0) + {1'b0, a[4:2]};
	endfunction

	function [10:0] clampGain;
		input [10:0] g;
		if ($signed(g) < $signed(`MBEQ_GAIN_MIN))
			clampGain = `MBEQ_GAIN_MIN;
		else if ($signed(g) > $signed(`MBEQ_GAIN_MAX))
			clampGain = `MBEQ_GAIN_MAX;
		else
			clampGain = g;
	endfunction

	function [31:0] clampBand;
		input [31:0] w;
		reg [12:0] wd;
		reg [7:0]  fq;
		begin
			wd = w[`MBEQ_WID_MSB:`MBEQ_WID_LSB];
			fq = w[`MBEQ_FREQ_MSB:`MBEQ_FREQ_LSB];
			if (wd < `MBEQ_WID_MIN) wd = `MBEQ_WID_MIN;
			if (wd > `MBEQ_WID_MAX) wd = `MBEQ_WID_MAX;
			if (fq > `MBEQ_FREQ_MAX) fq = `MBEQ_FREQ_MAX;
			clampBand = {wd, fq, clampGain(w[10:0])};
		end
	endfunction

	function signed [31:0] mulSh;
		input signed [31:0] a;
		input signed [31:0] b;
		input [4:0]         sh;
		reg signed [63:0] p;
		begin
			p = a * b;
			p = p >>> sh;
			mulSh = p[31:0];
		end
	endfunction

	// 0.1 dB code to Q12 linear, 60.2 codes per doubling
	function [31:0] dbToGain;
		input [10:0] g;
		reg signed [31:0] t;
		reg signed [31:0] e;
		reg [31:0]        m;
		begin
			t = $signed({{21{g[10]}}, g}) * $signed(`MBEQ_DB_TO_OCT);
			e = t >>> 12;
			m = `MBEQ_UNITY12 + {20'h00000, t[11:0]};
			if (e < 0)
				dbToGain = m >> (-e);
			else
				dbToGain = m << e;
		end
	endfunction

	// semitone index to Q16 tuning coefficient, 8 Hz at index 0
	function [31:0] semiToF;
		input [7:0] n;
		reg [31:0] t;
		reg [31:0] v;
		begin
			t = {24'h000000, n} * `MBEQ_SEMI_TO_OCT;
			v = (FBASE * (`MBEQ_UNITY12 + {20'h00000, t[11:0]}))
				<< t[15:12];
			v = v >> 12;
			semiToF = (v > `MBEQ_ONE16) ? `MBEQ_ONE16 : v;
		end
	endfunction

	function [31:0] widToQ;
		input [12:0] w;
		reg [31:0] v;
		begin
			v = {19'h00000, w} * `MBEQ_WID_TO_Q;
			widToQ = (v > `MBEQ_Q_MAX) ? `MBEQ_Q_MAX : v;
		end
	endfunction

	function [DW-1:0] sat;
		input signed [31:0] v;
		if (v > SMAX)
			sat = SMAX[DW-1:0];
		else if (v < SMIN)
			sat = SMIN[DW-1:0];
		else
			sat = v[DW-1:0];
	endfunction

	// ======================================
	// reset release
	reg rstMeta_r;
	reg rstSyncN_r;
	wire rstIntN = rstSyncN_r;
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rstMeta_r  <= 1'b0;
			rstSyncN_r <= 1'b0;
		end else begin
			rstMeta_r  <= 1'b1;
			rstSyncN_r <= rstMeta_r;
		end
	end

	// ======================================
	// registers
	reg [1:0]  variant_r;
	reg [1:0]  varLive_r;
	reg [31:0] bandShd_r  [0:11];
	reg [31:0] bandLive_r [0:11];
	reg [12:0] outShd_r   [0:1];
	reg [12:0] outLive_r  [0:1];
	reg [15:0] sampleCnt_r;
	reg [1:0]  state_r;
	reg [1:0]  cnt_r;
	integer iShd;
	integer iLive;
	integer iEng;
	integer iBuf;

	wire setupPh = psel && !penable;
	wire wrEn    = psel && penable && pwrite;
	wire outHit  = (paddr == `MBEQ_A_OUT0) || (paddr == `MBEQ_A_OUT1);
	wire anyHit  = bandHit(paddr) || outHit
		|| (paddr == `MBEQ_A_CTRL) || (paddr == `MBEQ_A_STAT);
	assign pready = 1'b1;

	always @(posedge clk_sys or negedge rstIntN) begin
		if (!rstIntN) begin
			variant_r <= `MBEQ_RST_VAR;
			prdata    <= 32'h00000000;
			pslverr   <= 1'b0;
			outShd_r[0] <= `MBEQ_RST_OUT;
			outShd_r[1] <= `MBEQ_RST_OUT;
			for (iShd = 0; iShd < 12; iShd = iShd + 1)
				bandShd_r[iShd] <= `MBEQ_RST_BAND;
		end else begin
			if (setupPh) begin
				pslverr <= !anyHit;
				prdata  <= 32'h00000000;
				if (!pwrite && bandHit(paddr))
					prdata <= bandShd_r[bandIndex(paddr)];
				else if (!pwrite && outHit)
					prdata <= {19'h00000, outShd_r[paddr[2]]};
				else if (!pwrite && paddr == `MBEQ_A_CTRL)
					prdata <= {30'h00000000, variant_r};
				else if (!pwrite && paddr == `MBEQ_A_STAT)
					prdata <= {sampleCnt_r, 13'h0000,
						state_r != S_IDLE, cnt_r};
			end
			if (wrEn && paddr == `MBEQ_A_CTRL)
				variant_r <= pwdata[1:0];
			if (wrEn && outHit)
				outShd_r[paddr[2]] <= {pwdata[12:11],
					clampGain(pwdata[10:0])};
			if (wrEn && bandHit(paddr))
				bandShd_r[bandIndex(paddr)] <= clampBand(pwdata);
		end
	end

	// settings adopted only while no sample is in flight
	always @(posedge clk_sys or negedge rstIntN) begin
		if (!rstIntN) begin
			varLive_r    <= `MBEQ_RST_VAR;
			outLive_r[0] <= `MBEQ_RST_OUT;
			outLive_r[1] <= `MBEQ_RST_OUT;
			for (iLive = 0; iLive < 12; iLive = iLive + 1)
				bandLive_r[iLive] <= `MBEQ_RST_BAND;
		end else if (state_r == S_IDLE) begin
			varLive_r    <= variant_r;
			outLive_r[0] <= outShd_r[0];
			outLive_r[1] <= outShd_r[1];
			for (iLive = 0; iLive < 12; iLive = iLive + 1)
				bandLive_r[iLive] <= bandShd_r[iLive];
		end
	end

	// ======================================
	// filter engine
	reg              chan_r;
	reg [2:0]        band_r;
	reg signed [31:0] acc_r;
	reg signed [31:0] lp_r [0:11];
	reg signed [31:0] bp_r [0:11];
	reg [DW-1:0]     smpR_r;
	reg [DW-1:0]     resL_r;
	reg [DW-1:0]     resR_r;

	wire setSel = (varLive_r == `MBEQ_V_DUAL) && chan_r;
	wire [3:0] pIdx = (setSel ? 4'h6 : 4'h0) + {1'b0, band_r};
	wire [3:0] sIdx = (chan_r ? 4'h6 : 4'h0) + {1'b0, band_r};
	wire [31:0] bw  = bandLive_r[pIdx];
	wire [12:0] ow  = outLive_r[setSel];
	wire [2:0] nBand = (varLive_r == `MBEQ_V_3BAND) ? 3'h3 :
		(varLive_r == `MBEQ_V_MONO) ? 3'h6 : 3'h5;
	wire lastBand = band_r == nBand - 3'h1;
	wire twoChan  = varLive_r != `MBEQ_V_MONO;
	wire bypass   = ow[`MBEQ_OUT_BYP];

	wire signed [31:0] fC = semiToF(bw[18:11]);
	wire signed [31:0] qC = (band_r < 3'h2
		|| varLive_r == `MBEQ_V_3BAND) ? `MBEQ_Q_FIXED
		: widToQ(bw[31:19]);
	wire signed [31:0] gC = dbToGain(bw[10:0]) - `MBEQ_UNITY12;
	wire signed [31:0] lp = lp_r[sIdx];
	wire signed [31:0] bp = bp_r[sIdx];
	wire signed [31:0] hp = acc_r - lp - mulSh(qC, bp, 5'd16);
	wire signed [31:0] bpN = bp + mulSh(fC, hp, 5'd16);
	wire signed [31:0] lpN = lp + mulSh(fC, bpN, 5'd16);
	wire signed [31:0] tap = (band_r == 3'h0) ? lpN :
		(band_r == 3'h1) ? hp : bpN;
	wire signed [31:0] yBand = acc_r + mulSh(gC, tap, 5'd12);
	wire signed [31:0] yOut = (varLive_r == `MBEQ_V_3BAND) ? acc_r :
		ow[`MBEQ_OUT_MUTE] ? 32'sh00000000 :
		mulSh($signed(dbToGain(ow[10:0])), acc_r, 5'd12);
	wire pushOk = cnt_r != 2'h2;

	assign inReady = state_r == S_IDLE;

	always @(posedge clk_sys or negedge rstIntN) begin
		if (!rstIntN) begin
			state_r     <= S_IDLE;
			chan_r      <= 1'b0;
			band_r      <= 3'h0;
			acc_r       <= 32'sh00000000;
			smpR_r      <= {DW{1'b0}};
			resL_r      <= {DW{1'b0}};
			resR_r      <= {DW{1'b0}};
			sampleCnt_r <= 16'h0000;
			for (iEng = 0; iEng < 12; iEng = iEng + 1) begin
				lp_r[iEng] <= 32'sh00000000;
				bp_r[iEng] <= 32'sh00000000;
			end
		end else begin
			case (state_r)
			S_IDLE: begin
				if (inValid) begin
					acc_r  <= {{(32-DW){inLeft[DW-1]}}, inLeft};
					smpR_r <= inRight;
					chan_r <= 1'b0;
					band_r <= 3'h0;
					state_r <= S_BAND;
				end
			end
			S_BAND: begin
				if (!bypass) begin
					lp_r[sIdx] <= lpN;
					bp_r[sIdx] <= bpN;
					acc_r      <= yBand;
				end
				band_r <= band_r + 3'h1;
				if (lastBand || bypass)
					state_r <= S_OUTG;
			end
			S_OUTG: begin
				band_r <= 3'h0;
				if (!chan_r) begin
					resL_r <= sat(yOut);
					resR_r <= sat(yOut);
				end else begin
					resR_r <= sat(yOut);
				end
				if (!chan_r && twoChan) begin
					chan_r  <= 1'b1;
					acc_r   <= {{(32-DW){smpR_r[DW-1]}}, smpR_r};
					state_r <= S_BAND;
				end else begin
					state_r <= S_PUSH;
				end
			end
			S_PUSH: begin
				if (pushOk) begin
					sampleCnt_r <= sampleCnt_r + 16'h0001;
					state_r     <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// ======================================
	// two-entry output buffer
	reg [DW-1:0] bufL_r [0:1];
	reg [DW-1:0] bufR_r [0:1];
	reg          wrPtr_r;
	reg          rdPtr_r;
	wire push = (state_r == S_PUSH) && pushOk;
	wire pop  = outValid && outReady;

	assign outValid = cnt_r != 2'h0;
	assign outLeft  = bufL_r[rdPtr_r];
	assign outRight = bufR_r[rdPtr_r];

	always @(posedge clk_sys or negedge rstIntN) begin
		if (!rstIntN) begin
			wrPtr_r <= 1'b0;
			rdPtr_r <= 1'b0;
			cnt_r   <= 2'h0;
			for (iBuf = 0; iBuf < 2; iBuf = iBuf + 1) begin
				bufL_r[iBuf] <= {DW{1'b0}};
				bufR_r[iBuf] <= {DW{1'b0}};
			end
		end else begin
			if (push) begin
				bufL_r[wrPtr_r] <= resL_r;
				bufR_r[wrPtr_r] <= resR_r;
				wrPtr_r <= !wrPtr_r;
			end
			if (pop)
				rdPtr_r <= !rdPtr_r;
			if (push && !pop)
				cnt_r <= cnt_r + 2'h1;
			else if (pop && !push)
				cnt_r <= cnt_r - 2'h1;
		end
	end
endmodule
`default_nettype wire

// *** tb/mbeq_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// port checks
module mbeq_properties #(
	parameter DW = 16
) (
	input wire logic          clk_sys,
	input wire logic          rstn,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [7:0]    paddr,
	input wire logic          pready,
	input wire logic [31:0]   prdata,
	input wire logic          pslverr,
	input wire logic          inValid,
	input wire logic          inReady,
	input wire logic          outValid,
	input wire logic          outReady,
	input wire logic [DW-1:0] outLeft,
	input wire logic [DW-1:0] outRight
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire acc  = psel & penable;
	wire take = inValid & inReady;
	wire hole = paddr[7:3] == 5'h0B || paddr[7:3] == 5'h0F;
	AST_READY_UP:
		assert property (pready) else $error("pready low");
	AST_HOLE_ERR:
		assert property (acc && hole |-> pslverr)
		else $error("hole without error");
	AST_CTRL_OK:
		assert property (acc && paddr == 8'h00 |-> !pslverr)
		else $error("error on control");
	AST_ERR_ZERO:
		assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	AST_RD_HOLD:
		assert property ($changed(prdata) |-> $past(psel && !penable))
		else $error("read data moved");
	AST_TAKE_BUSY:
		assert property (take |=> !inReady [*3])
		else $error("ready too soon");
	AST_LATENCY:
		assert property (take && !outValid |=>
			!outValid [*3] ##[1:40] outValid)
		else $error("result late or early");
	AST_OUT_HOLD:
		assert property (outValid && !outReady |=>
			outValid && $stable(outLeft) && $stable(outRight))
		else $error("stalled word moved");
	AST_NO_LOSS:
		assert property ($fell(outValid) |-> $past(outReady))
		else $error("word dropped");
	COV_TAKE: cover property (take);
	COV_STALL: cover property (outValid && !outReady);
	COV_HOLE: cover property (acc && hole);
endmodule
bind mbeq_top mbeq_properties #(.DW(DW)) u_props (
	.clk_sys  (clk_sys),
	.rstn     (rstn),
	.psel     (psel),
	.penable  (penable),
	.pwrite   (pwrite),
	.paddr    (paddr),
	.pready   (pready),
	.prdata   (prdata),
	.pslverr  (pslverr),
	.inValid  (inValid),
	.inReady  (inReady),
	.outValid (outValid),
	.outReady (outReady),
	.outLeft  (outLeft),
	.outRight (outRight)
);
`default_nettype wire

// *** tb/mbeq_stream_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========
// sample source and sink
module mbeq_stream_partner (
	input  wire logic        clk_sys,
	input  wire logic        sendReq,
	input  wire logic [15:0] sendLeft,
	input  wire logic [15:0] sendRight,
	input  wire logic        stall,
	output var  logic        inValid = 1'b0,
	input  wire logic        inReady,
	output var  logic [15:0] inLeft = 16'h0000,
	output var  logic [15:0] inRight = 16'h0000,
	input  wire logic        outValid,
	output var  logic        outReady = 1'b0,
	input  wire logic [15:0] outLeft,
	input  wire logic [15:0] outRight,
	output var  logic [15:0] gotLeft = 16'h0000,
	output var  logic [15:0] gotRight = 16'h0000,
	output var  int          gotCount = 0
);
	always @(posedge clk_sys) begin
		outReady <= !stall;
		if (outValid && outReady) begin
			gotLeft  <= outLeft;
			gotRight <= outRight;
			gotCount <= gotCount + 1;
		end
		if (inValid && inReady) begin
			inValid <= 1'b0;
			inLeft  <= ~inLeft;
			inRight <= ~inRight;
		end else if (sendReq && !inValid) begin
			inValid <= 1'b1;
			inLeft  <= sendLeft;
			inRight <= sendRight;
		end
	end
endmodule
`default_nettype wire

// *** tb/multiband_parametric_eq_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mbeq_defines.vh"
// ========
// bench top
module multiband_parametric_eq_tb_top;
	logic        clk_sys   = 1'b0;
	logic        rstn      = 1'b0;
	logic        psel      = 1'b0;
	logic        penable   = 1'b0;
	logic        pwrite    = 1'b0;
	logic [7:0]  paddr     = 8'h00;
	logic [31:0] pwdata    = 32'h00000000;
	logic        sendReq   = 1'b0;
	logic        stall     = 1'b0;
	logic [15:0] sendLeft  = 16'h0000;
	logic [15:0] sendRight = 16'h0000;
	logic [31:0] rd;
	logic        err;
	wire         pready, pslverr, inValid, inReady, outValid, outReady;
	wire  [31:0] prdata;
	wire  [15:0] inLeft, inRight, outLeft, outRight, gotLeft, gotRight;
	int          gotCount;
	int          sent      = 0;
	int          errCount  = 0;
	int          testsRun  = 0;
	mbeq_top dut (
		.clk_sys (clk_sys), .rstn (rstn), .psel (psel), .penable (penable),
		.pwrite (pwrite), .paddr (paddr), .pwdata (pwdata),
		.pready (pready), .prdata (prdata), .pslverr (pslverr),
		.inValid (inValid), .inReady (inReady), .inLeft (inLeft),
		.inRight (inRight), .outValid (outValid), .outReady (outReady),
		.outLeft (outLeft), .outRight (outRight)
	);
	mbeq_stream_partner partner (
		.clk_sys (clk_sys), .sendReq (sendReq), .sendLeft (sendLeft),
		.sendRight (sendRight), .stall (stall), .inValid (inValid),
		.inReady (inReady), .inLeft (inLeft), .inRight (inRight),
		.outValid (outValid), .outReady (outReady), .outLeft (outLeft),
		.outRight (outRight), .gotLeft (gotLeft), .gotRight (gotRight),
		.gotCount (gotCount)
	);
	always #50 clk_sys = ~clk_sys;
	// ========
	// shared tasks
	task automatic check(input string n, input logic [31:0] e, g);
		testsRun++;
		if (g !== e) begin
			errCount++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
	                   input logic [31:0] d);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdChk(input string n, input logic [7:0] a,
	                     input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		check(n, e, rd);
	endtask
	task automatic push(input logic [15:0] l, r);
		int k;
		@(posedge clk_sys);
		sendLeft  <= l;
		sendRight <= r;
		sendReq   <= 1'b1;
		@(posedge clk_sys);
		sendReq <= 1'b0;
		sent++;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (!(inValid === 1'b1 && inReady === 1'b1) && k < 100);
	endtask
	task automatic eqRun(input logic [31:0] c, o0, o1,
	                     input logic [15:0] l, r);
		int k;
		wr(`MBEQ_A_CTRL, c);
		wr(`MBEQ_A_OUT0, o0);
		wr(`MBEQ_A_OUT1, o1);
		push(l, r);
		for (k = 0; k < 200 && gotCount < sent; k++) @(posedge clk_sys);
		check("result count", sent, gotCount);
	endtask
	// ========
	// scenarios
	task automatic t_regs;
		int i;
		rdChk("control reset", `MBEQ_A_CTRL, 32'h00000001);
		rdChk("output reset", `MBEQ_A_OUT1, 32'h00000000);
		rdChk("band reset", 8'h74, `MBEQ_RST_BAND);
		wr(8'h40, 32'hFFFFFBFF);
		rdChk("low shelf clamp", 8'h40, 32'h9C4458F0);
		wr(8'h44, 32'h00000400);
		rdChk("high shelf clamp", 8'h44, 32'h005004EA);
		wr(8'h48, 32'h9C445CEA);
		rdChk("peak limits", 8'h48, 32'h9C445CEA);
		wr(`MBEQ_A_OUT0, 32'h000003FF);
		rdChk("output clamp", `MBEQ_A_OUT0, 32'h000000F0);
		wr(8'h58, 32'h12345678);
		check("hole error", 32'h1, {31'h0, err});
		rdChk("hole read", 8'h58, 32'h00000000);
		wr(`MBEQ_A_STAT, 32'hFFFFFFFF);
		rdChk("status idle", `MBEQ_A_STAT, 32'h00000000);
		for (i = 0; i < 3; i++) wr(8'(8'h40 + 4 * i), `MBEQ_RST_BAND);
		$display("test registers done");
	endtask
	task automatic t_modes;
		eqRun(32'h1, 32'h1000, 32'h0, 16'h1234, 16'hEDCB);
		check("bypass left", 16'h1234, gotLeft);
		check("bypass right", 16'hEDCB, gotRight);
		eqRun(32'h1, 32'h0800, 32'h0, 16'h1234, 16'h1234);
		check("muted", 32'h0, {gotLeft, gotRight});
		eqRun(32'h1, 32'h0, 32'h0800, 16'h0800, 16'h0800);
		check("ganged sides", gotLeft, gotRight);
		check("set one unused", 1, gotLeft !== 16'h0);
		eqRun(32'h2, 32'h1000, 32'h0800, 16'h2222, 16'h3333);
		check("dual left", 16'h2222, gotLeft);
		check("dual right", 16'h0, gotRight);
		eqRun(32'h0, 32'h1800, 32'h0, 16'h4444, 16'h5555);
		check("three band out", 32'h44445555, {gotLeft, gotRight});
		eqRun(32'h3, 32'h1000, 32'h0, 16'h0456, 16'h7000);
		check("mono mirror", 32'h04560456, {gotLeft, gotRight});
		eqRun(32'h1, 32'h003C, 32'h0, 16'h0800, 16'h0800);
		check("6 dB left", 1, gotLeft > 16'h0FC0 && gotLeft < 16'h1040);
		check("6 dB right", 1, gotRight > 16'h0FC0 && gotRight < 16'h1040);
		$display("test modes done");
	endtask
	task automatic t_buffer;
		int k;
		wr(`MBEQ_A_CTRL, 32'h1);
		wr(`MBEQ_A_OUT0, 32'h1000);
		stall <= 1'b1;
		push(16'h0101, 16'hFEFE);
		push(16'h0202, 16'hFDFD);
		push(16'h0303, 16'hFCFC);
		rd = 32'h0;
		for (k = 0; k < 40 && rd[2:0] !== 3'h6; k++)
			apb(1'b0, `MBEQ_A_STAT, 32'h0);
		check("full status", 32'h6, {29'h0, rd[2:0]});
		check("ready while full", 32'h0, {31'h0, inReady});
		stall <= 1'b0;
		for (k = 0; k < 200 && gotCount < sent; k++) @(posedge clk_sys);
		check("last drained", 32'h0303FCFC, {gotLeft, gotRight});
		rdChk("done count", `MBEQ_A_STAT, 32'(sent) << 16);
		$display("test buffer done");
	endtask
	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", testsRun, errCount);
		if (errCount == 0 && testsRun > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_regs;
		t_modes;
		t_buffer;
		summarize;
	end
	initial begin
		#2000000;
		errCount++;
		summarize;
	end
endmodule
`default_nettype wire
